// >>> hw/nvm_ctrl_pkg.sv
// package for the data eeprom erase/program controller
// assumes a single 125 MHz system clock domain
package nvm_ctrl_pkg;
   // control register fields
   localparam int CTRL_W = 16;
   localparam int START_BIT = 15;
   localparam int ARM_BIT = 14;
   localparam int ABORT_BIT = 13;
   localparam int OP_LSB = 0;
   localparam int OP_W = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
   // operation codes in the low control bits
   localparam logic [OP_W-1:0] OP_WORD_ERASE = 7'h44;
   localparam logic [OP_W-1:0] OP_WORD_PROG = 7'h04;
   localparam logic [OP_W-1:0] OP_BLOCK_PROG = 7'h0a;
   // unlock keys
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // address and latches
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int LATCH_N = 16;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
   // cycle timing
   localparam int CLK_MHZ = 125;
   localparam int CYCLE_TIME_US = 2000;
   localparam int CYCLE_CLKS = CYCLE_TIME_US * CLK_MHZ;
   localparam int PWRUP_CLKS = 8192;
endpackage

// >>> hw/nvm_cycle_timer.sv
// down-counter timing one erase/program cycle
// assumes start is a one-cycle pulse; done pulses once at expiry
`timescale 1ns/1ps
`default_nettype none
module nvm_cycle_timer #(
   parameter int CYCLE_CLKS = 250000
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   typedef struct packed {
      logic [31:0] cnt;
      logic busy;
      logic done;
   } tmr_s;
   tmr_s st_r;
   tmr_s st_nxt;

   // elaboration-time guard: counts below two are rejected; a zero count would wrap the down-counter
   if (CYCLE_CLKS < 2)
   begin
      $error("cycle length too short");
   end

   // count down while busy; a start during a cycle is ignored
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (st_r.busy)
      begin
         if (st_r.cnt == 32'h00000001)
         begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end
         st_nxt.cnt = st_r.cnt - 32'h00000001;
      end
      else if (start_i)
      begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt = 32'(CYCLE_CLKS);
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign busy_o = st_r.busy;
   assign done_o = st_r.done;
endmodule
`default_nettype wire

// >>> hw/nvm_eeprom_ctrl.sv
// data eeprom erase/program control: control, address, key regs and word latches
// assumes cpu-side write strobes are one-cycle pulses synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module nvm_eeprom_ctrl #(
   parameter int CYCLE_CLKS = nvm_ctrl_pkg::CYCLE_CLKS,
   parameter int PWRUP_CLKS = nvm_ctrl_pkg::PWRUP_CLKS
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic por_i,
   input wire logic ctrl_wr_i,
   input wire logic [nvm_ctrl_pkg::CTRL_W-1:0] ctrl_wdata_i,
   input wire logic key_wr_i,
   input wire logic [7:0] key_wdata_i,
   input wire logic addr_lo_wr_i,
   input wire logic addr_hi_wr_i,
   input wire logic [15:0] addr_wdata_i,
   input wire logic tbl_wr_i,
   input wire logic [nvm_ctrl_pkg::ADDR_W-1:0] tbl_addr_i,
   input wire logic [nvm_ctrl_pkg::DATA_W-1:0] tbl_wdata_i,
   input wire logic done_flag_clr_i,
   input wire logic abort_flag_clr_i,
   output logic [nvm_ctrl_pkg::CTRL_W-1:0] ctrl_o,
   output logic [nvm_ctrl_pkg::ADDR_W-1:0] addr_o,
   output logic done_flag_o,
   output logic busy_o,
   output logic rd_valid_o,
   output logic mem_erase_o,
   output logic mem_prog_o,
   output logic [4:0] mem_words_o,
   output logic [nvm_ctrl_pkg::ADDR_W-1:0] mem_addr_o,
   output logic [nvm_ctrl_pkg::DATA_W*nvm_ctrl_pkg::LATCH_N-1:0] mem_data_o
);
   localparam int DW = nvm_ctrl_pkg::DATA_W;
   localparam int LN = nvm_ctrl_pkg::LATCH_N;

   typedef enum logic [1:0] {UNLK_IDLE, UNLK_KEY1, UNLK_KEY2} unlk_e;

   typedef struct packed {
      logic [nvm_ctrl_pkg::CTRL_W-1:0] ctrl;
      logic [nvm_ctrl_pkg::ADDR_W-1:0] addr;
      unlk_e unlk;
      logic done_flag;
      logic running;
      logic run_mark;
      logic pwr_ok;
      logic [31:0] pwr_cnt;
      logic [4:0] words;
      logic erase;
      logic prog;
      logic [nvm_ctrl_pkg::ADDR_W-1:0] op_addr;
      logic [LN-1:0][DW-1:0] latch;
      logic rd_valid;
   } ctl_s;

   ctl_s st_r;
   ctl_s st_nxt;
   logic tmr_start;
   logic tmr_busy;
   logic tmr_done;

   // elaboration-time guard: the latch index is four address bits wide
   if (PWRUP_CLKS < 1 || LN != 16)
   begin
      $error("unsupported parameter values");
   end

   // word count served by an operation code; zero marks an unknown code
   function automatic logic [4:0] op_words(input logic [nvm_ctrl_pkg::OP_W-1:0] op);
      logic [4:0] n;
      n = 5'h00;
      if (op == nvm_ctrl_pkg::OP_WORD_ERASE || op == nvm_ctrl_pkg::OP_WORD_PROG)
         n = 5'h01;
      else if (op == nvm_ctrl_pkg::OP_BLOCK_PROG)
         n = 5'h10;
      return n;
   endfunction

   // cycle length counter kept outside so it can be shortened in simulation
   nvm_cycle_timer #(
      .CYCLE_CLKS(CYCLE_CLKS)
   ) u_timer (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .start_i(tmr_start),
      .busy_o(tmr_busy),
      .done_o(tmr_done)
   );

   // whole next-state: registers, unlock sequencer, cycle launch and completion
   always_comb
   begin
      logic start_req;
      logic [4:0] n;
      start_req = 1'b0;
      n = 5'h00;
      st_nxt = st_r;
      tmr_start = 1'b0;

      // power-up hold-off gates every launch
      if (!st_r.pwr_ok)
      begin
         st_nxt.pwr_cnt = st_r.pwr_cnt + 32'h00000001;
         if (st_r.pwr_cnt == 32'(PWRUP_CLKS - 1))
            st_nxt.pwr_ok = 1'b1;
      end

      // table writes fill latches by low address bits and update the address
      if (tbl_wr_i && !st_r.running)
      begin
         st_nxt.latch[tbl_addr_i[4:1]] = tbl_wdata_i;
         st_nxt.addr = tbl_addr_i;
      end
      if (addr_lo_wr_i && !st_r.running)
         st_nxt.addr[15:0] = addr_wdata_i;
      if (addr_hi_wr_i && !st_r.running)
         st_nxt.addr[23:16] = addr_wdata_i[7:0];

      // unlock sequencer: any stray key, control, table or address write drops it
      unique case (st_r.unlk)
         UNLK_IDLE:
            if (key_wr_i && key_wdata_i == nvm_ctrl_pkg::KEY_FIRST)
               st_nxt.unlk = UNLK_KEY1;
         UNLK_KEY1:
            if (key_wr_i && key_wdata_i == nvm_ctrl_pkg::KEY_SECOND && !ctrl_wr_i)
               st_nxt.unlk = UNLK_KEY2;
            else if (key_wr_i || ctrl_wr_i || tbl_wr_i || addr_lo_wr_i || addr_hi_wr_i)
               st_nxt.unlk = UNLK_IDLE;
         UNLK_KEY2:
            if (key_wr_i || ctrl_wr_i || tbl_wr_i || addr_lo_wr_i || addr_hi_wr_i)
               st_nxt.unlk = UNLK_IDLE; // one shot per operation
      endcase

      // control write: start can only be set, never cleared by software
      if (ctrl_wr_i)
      begin
         st_nxt.ctrl[nvm_ctrl_pkg::ARM_BIT] = ctrl_wdata_i[nvm_ctrl_pkg::ARM_BIT];
         if (!st_r.running)
         begin
            st_nxt.ctrl[nvm_ctrl_pkg::OP_W-1:0] = ctrl_wdata_i[nvm_ctrl_pkg::OP_W-1:0];
            st_nxt.ctrl[nvm_ctrl_pkg::ABORT_BIT] = st_r.ctrl[nvm_ctrl_pkg::ABORT_BIT];
         end
         // arm must already be set from an earlier write
         start_req = ctrl_wdata_i[nvm_ctrl_pkg::START_BIT]
                   && st_r.ctrl[nvm_ctrl_pkg::ARM_BIT]
                   && st_r.unlk == UNLK_KEY2;
      end

      // launch decodes the operation as registered before this write
      n = op_words(st_r.ctrl[nvm_ctrl_pkg::OP_W-1:0]);
      if (start_req && !st_r.running && st_r.pwr_ok && n != 5'h00)
      begin
         st_nxt.ctrl[nvm_ctrl_pkg::START_BIT] = 1'b1;
         st_nxt.running = 1'b1;
         st_nxt.rd_valid = 1'b0;
         st_nxt.words = n;
         st_nxt.erase = st_r.ctrl[6]; // erase flag inside the op code
         st_nxt.prog = !st_r.ctrl[6];
         st_nxt.op_addr = st_r.addr;
         tmr_start = 1'b1;
      end

      // completion leaves arm alone, clears start, sets the done flag
      if (tmr_done)
      begin
         st_nxt.ctrl[nvm_ctrl_pkg::START_BIT] = 1'b0;
         st_nxt.running = 1'b0;
         st_nxt.erase = 1'b0;
         st_nxt.prog = 1'b0;
         st_nxt.rd_valid = 1'b1;
      end

      // software clears flags; a same-cycle set wins
      if (done_flag_clr_i)
         st_nxt.done_flag = 1'b0;
      if (tmr_done)
         st_nxt.done_flag = 1'b1;
      if (abort_flag_clr_i)
         st_nxt.ctrl[nvm_ctrl_pkg::ABORT_BIT] = 1'b0;

      // run_mark survives the async reset, so a cut cycle shows as mark set, running clear
      if (st_r.run_mark && !st_r.running)
         st_nxt.ctrl[nvm_ctrl_pkg::ABORT_BIT] = 1'b1; // set wins over clear
      st_nxt.run_mark = st_nxt.running;
   end

   // async reset spares address, latches, abort bit and run_mark so a cut cycle is
   // flagged one edge after release; power-on reset clears everything except rd_valid, which it sets
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r.ctrl[nvm_ctrl_pkg::START_BIT] <= 1'b0;
         st_r.ctrl[nvm_ctrl_pkg::ARM_BIT] <= 1'b0;
         st_r.ctrl[12:0] <= 13'h0000;
         st_r.unlk <= UNLK_IDLE;
         st_r.done_flag <= 1'b0;
         st_r.running <= 1'b0;
         st_r.pwr_ok <= 1'b0;
         st_r.pwr_cnt <= 32'h00000000;
         st_r.words <= 5'h00;
         st_r.erase <= 1'b0;
         st_r.prog <= 1'b0;
         st_r.rd_valid <= 1'b1;
      end
      else if (por_i)
      begin
         st_r.ctrl <= nvm_ctrl_pkg::CTRL_RESET;
         st_r.addr <= nvm_ctrl_pkg::ADDR_RESET;
         st_r.op_addr <= nvm_ctrl_pkg::ADDR_RESET;
         st_r.latch <= '0;
         st_r.run_mark <= 1'b0;
         st_r.unlk <= UNLK_IDLE;
         st_r.done_flag <= 1'b0;
         st_r.running <= 1'b0;
         st_r.pwr_ok <= 1'b0;
         st_r.pwr_cnt <= 32'h00000000;
         st_r.words <= 5'h00;
         st_r.erase <= 1'b0;
         st_r.prog <= 1'b0;
         st_r.rd_valid <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // outputs straight from state flops
   assign ctrl_o = st_r.ctrl;
   assign addr_o = st_r.addr;
   assign done_flag_o = st_r.done_flag;
   assign busy_o = st_r.running;
   assign rd_valid_o = st_r.rd_valid;
   assign mem_erase_o = st_r.erase;
   assign mem_prog_o = st_r.prog;
   assign mem_words_o = st_r.words;
   assign mem_addr_o = st_r.op_addr;
   assign mem_data_o = st_r.latch;
endmodule
`default_nettype wire

// >>> tb/nvm_eeprom_ctrl_asserts.sv
// port checker for the eeprom erase/program controller
// assumes one clock domain; bound onto every controller instance
`timescale 1ns/1ps
`default_nettype none
module nvm_eeprom_ctrl_chk #(
   parameter int CYCLE_CLKS = nvm_ctrl_pkg::CYCLE_CLKS
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic ctrl_wr_i,
   input wire logic [15:0] ctrl_wdata_i,
   input wire logic tbl_wr_i,
   input wire logic [23:0] tbl_addr_i,
   input wire logic done_flag_clr_i,
   input wire logic [15:0] ctrl_o,
   input wire logic [23:0] addr_o,
   input wire logic done_flag_o,
   input wire logic busy_o,
   input wire logic rd_valid_o,
   input wire logic mem_erase_o,
   input wire logic mem_prog_o,
   input wire logic [4:0] mem_words_o
);
   // busy spans the timer length plus the completion edge
   localparam int RUN_LEN = CYCLE_CLKS + 1;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // busy cycles counted in helper logic: the real cycle is far too long to unroll
   logic [31:0] run_cnt;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         run_cnt <= 32'h00000000;
      else if (busy_o)
         run_cnt <= run_cnt + 32'h00000001;
      else
         run_cnt <= 32'h00000000;
   end
   // a cycle ends after its full length with start low and the flag up
   sequence s_run_end;
      !busy_o && done_flag_o && !ctrl_o[15] && run_cnt == 32'(RUN_LEN);
   endsequence
   property p_run_len; $fell(busy_o) |-> s_run_end; endproperty
   a_run_len: assert property (p_run_len) else $error("cycle length off");
   property p_run_cap; busy_o |-> run_cnt < 32'(RUN_LEN); endproperty
   a_run_cap: assert property (p_run_cap) else $error("cycle runs too long");
   property p_launch; $rose(busy_o) |-> $past(ctrl_wr_i && ctrl_wdata_i[15] && ctrl_o[14]); endproperty
   a_launch: assert property (p_launch) else $error("launch without armed start");
   property p_arm_kept; $fell(busy_o) && !$past(ctrl_wr_i) |-> ctrl_o[14] == $past(ctrl_o[14]); endproperty
   a_arm_kept: assert property (p_arm_kept) else $error("arm changed at end");
   property p_start_held; busy_o |-> ctrl_o[15]; endproperty
   a_start_held: assert property (p_start_held) else $error("start dropped early");
   property p_erase; $rose(busy_o) |-> mem_erase_o == (ctrl_o[6:0] == 7'h44); endproperty
   a_erase: assert property (p_erase) else $error("erase select wrong");
   // block program covers all latches, word program only one
   property p_words; $rose(busy_o) && mem_prog_o |-> mem_words_o == (ctrl_o[6:0] == 7'h0a ? 5'h10 : 5'h01); endproperty
   a_words: assert property (p_words) else $error("word count wrong");
   property p_rd; busy_o |-> !rd_valid_o; endproperty
   a_rd: assert property (p_rd) else $error("read valid during cycle");
   property p_done_keep; done_flag_o && !done_flag_clr_i |=> done_flag_o; endproperty
   a_done_keep: assert property (p_done_keep) else $error("done flag lost");
   property p_addr; tbl_wr_i && !busy_o |=> addr_o == $past(tbl_addr_i); endproperty
   a_addr: assert property (p_addr) else $error("address not captured");
endmodule
bind nvm_eeprom_ctrl nvm_eeprom_ctrl_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.clk_sys_i, .sys_rst_i,
   .ctrl_wr_i, .ctrl_wdata_i, .tbl_wr_i, .tbl_addr_i, .done_flag_clr_i, .ctrl_o, .addr_o,
   .done_flag_o, .busy_o, .rd_valid_o, .mem_erase_o, .mem_prog_o, .mem_words_o);
`default_nettype wire

// >>> tb/tb_data_eeprom_erase_program_ctrl.sv
// self-checking bench for the eeprom erase/program controller
// assumes short cycle and power-up counts so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module tb_data_eeprom_erase_program_ctrl;
   localparam int CYC = 20;
   localparam int PWR = 12;
   localparam int ALO = 0, ACLR = 2, DCLR = 3, TBL = 4, KEY = 5, CTL = 6;
   logic clk_sys_i = 0, sys_rst_i = 1, por_i = 1, ctrl_wr_i = 0, key_wr_i = 0;
   logic addr_lo_wr_i = 0, addr_hi_wr_i = 0, tbl_wr_i = 0, done_flag_clr_i = 0;
   logic abort_flag_clr_i = 0;
   logic [15:0] ctrl_wdata_i = 16'h0000, addr_wdata_i = 16'h0000, tbl_wdata_i = 16'h0000;
   logic [7:0] key_wdata_i = 8'h00;
   logic [23:0] tbl_addr_i = 24'h000000;
   logic [15:0] ctrl_o;
   logic [23:0] addr_o, mem_addr_o;
   logic done_flag_o, busy_o, rd_valid_o, mem_erase_o, mem_prog_o;
   logic [4:0] mem_words_o;
   logic [255:0] mem_data_o;
   int error_cnt = 0, cmp_count = 0;
   // ordinary operations: op code, erase, program, word count
   logic [13:0] rows [3] = '{{7'h44, 1'b1, 1'b0, 5'h01}, {7'h04, 1'b0, 1'b1, 5'h01},
      {7'h0a, 1'b0, 1'b1, 5'h10}};
   nvm_eeprom_ctrl #(.CYCLE_CLKS(CYC), .PWRUP_CLKS(PWR)) uut (.clk_sys_i, .sys_rst_i, .por_i,
      .ctrl_wr_i, .ctrl_wdata_i, .key_wr_i, .key_wdata_i, .addr_lo_wr_i, .addr_hi_wr_i,
      .addr_wdata_i, .tbl_wr_i, .tbl_addr_i, .tbl_wdata_i, .done_flag_clr_i, .abort_flag_clr_i,
      .ctrl_o, .addr_o, .done_flag_o, .busy_o, .rd_valid_o, .mem_erase_o, .mem_prog_o,
      .mem_words_o, .mem_addr_o, .mem_data_o);
   initial
      forever #4 clk_sys_i = ~clk_sys_i;
   task automatic stop_test;
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [255:0] s, input logic [255:0] e);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
   endtask
   // one-cycle write strobe of kind k; a gap cycle follows so strobes never merge
   task automatic pulse(input int k, input logic [15:0] d);
      @(negedge clk_sys_i);
      {ctrl_wr_i, key_wr_i, tbl_wr_i, done_flag_clr_i, abort_flag_clr_i, addr_hi_wr_i,
         addr_lo_wr_i} = 7'h01 << k;
      ctrl_wdata_i = d;
      key_wdata_i = d[7:0];
      tbl_wdata_i = d;
      addr_wdata_i = d;
      @(negedge clk_sys_i);
      {ctrl_wr_i, key_wr_i, tbl_wr_i, done_flag_clr_i, abort_flag_clr_i, addr_hi_wr_i,
         addr_lo_wr_i} = 7'h00;
   endtask
   // op write, both keys (second may be swapped for another write), then start
   task automatic launch(input logic [15:0] pre, input int k2);
      pulse(CTL, pre);
      pulse(KEY, 16'h0055); // keys follow with nothing in between
      pulse(k2, 16'h00aa);
      pulse(CTL, 16'hc000 | (pre & 16'h007f));
   endtask
   task automatic wait_done;
      for (int i = 0; i < 3 * CYC && done_flag_o !== 1'b1; i++)
         @(negedge clk_sys_i);
   endtask
   // watchdog sized well above the whole sequence
   initial
   begin
      #(8 * 4000);
      error_cnt++;
      stop_test;
   end
   initial
   begin
      repeat (5) @(negedge clk_sys_i);
      sys_rst_i = 0;
      @(negedge clk_sys_i);
      por_i = 0;
      chk({ctrl_o, addr_o, done_flag_o, busy_o, rd_valid_o}, 43'h1);
      // power-up timer still running, so this must not start
      launch(16'h4044, KEY);
      chk(busy_o, 1'b0);
      repeat (PWR) @(negedge clk_sys_i);
      for (int i = 0; i < 16; i++)
      begin
         tbl_addr_i = 24'h7ff000 + 24'(2 * i);
         pulse(TBL, 16'h1000 + 16'(i));
      end
      chk(addr_o, 24'h7ff01e);
      chk({mem_data_o[255:240], mem_data_o[15:0]}, 32'h100f1000);
      foreach (rows[r])
      begin
         launch({9'h080, rows[r][13:7]}, KEY); // erase row runs before word program
         chk({busy_o, ctrl_o[15], rd_valid_o, mem_erase_o, mem_prog_o, mem_words_o},
            {3'b110, rows[r][6:0]});
         chk(mem_addr_o, 24'h7ff01e);
         pulse(CTL, {9'h080, rows[r][13:7]});
         chk(ctrl_o[15], 1'b1);
         wait_done;
         chk({done_flag_o, busy_o, ctrl_o[15:14]}, 4'b1001);
         chk({rd_valid_o, mem_erase_o, mem_prog_o}, 3'b100);
         pulse(DCLR, 16'h0000);
         chk(done_flag_o, 1'b0);
      end
      // arm dropped mid-cycle: the cycle still completes
      launch(16'h4044, KEY);
      pulse(CTL, 16'h0000);
      wait_done;
      chk({done_flag_o, ctrl_o[15:14]}, 3'b100);
      pulse(DCLR, 16'h0000);
      // arm and start in the same write
      launch(16'h0044, KEY);
      chk(busy_o, 1'b0);
      // a stray address write in place of the second key
      launch(16'h4044, ALO);
      chk({busy_o, addr_o}, {1'b0, 24'h7f00aa});
      // reset in mid-cycle flags the abort and keeps the address
      launch(16'h4044, KEY);
      sys_rst_i = 1;
      @(negedge clk_sys_i);
      chk({busy_o, ctrl_o[15:14], rd_valid_o}, 4'b0001);
      sys_rst_i = 0;
      // the interruption is flagged at the first edge after release
      @(negedge clk_sys_i);
      chk({busy_o, ctrl_o[15:13], addr_o}, {4'b0001, 24'h7f00aa});
      pulse(ACLR, 16'h0000);
      chk(ctrl_o[13], 1'b0);
      stop_test;
   end
endmodule
`default_nettype wire
